// ---- core/pmcs_pkg.sv ----
/*
  constants, field layouts and carrier types of the conversion sequencer
  assumes one 125 MHz clock and a word-wide register port
*/
// Operation
// (R01) one converter is shared by shunt, bus and temperature through a selector
// (R02) power and energy use previous current and the newest bus sample
// (R03) with one average each result is published as its conversion ends
// (R04) averaging sums samples per quantity, then averages, power and output load
// (R05) energy and charge accumulate every cycle, never averaged
// (R06) arithmetic runs alongside conversions and adds no time
// (R07) temperature is converted before each shunt and corrects current drift
// (R08) modes restrict the sequence to current only or bus only
// (R09) each input has its own conversion period, 50 us to 4.12 ms
// (R10) current exists only after temperature and shunt both finish
// (R11) enabled inputs convert in turn, sequence repeats until averaging count
// (R12) outputs hold until a complete result replaces them; reads disturb nothing
// (R13) continuous mode repeats the sequence forever
// (R14) triggered mode runs one sequence then shuts down until mode rewritten
// (R15) any mode write aborts and restarts the sequence
// (R16) done flag rises only after all conversions and averaging finish
// (R17) done flag clears on non-shutdown setup write or alert register read
// (R18) energy and charge are invalid in triggered mode
// (R19) start delay 0 to 510 ms in 2 ms steps, reset value none
// (R20) decimation filter follows the selected period, settles in one cycle
// (R21) averaging counts 1 to 1024, one count for all inputs
// (R22) timing comes from the oscillator; allow 300 us to stabilise
// (R23) shutdown stays idle with registers reachable until a conversion mode
// (R24) average is sum divided by count, by shifting
// (R25) all outputs of one sequence update in the same cycle; with one average the code publishes each at its conversion end
`default_nettype none

package pmcs_pkg;

  localparam int CLK_PERIOD_NS = 8;

  // register offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_ADC_CFG = 8'h04;
  localparam logic [7:0] OFF_CURRENT = 8'h08;
  localparam logic [7:0] OFF_VBUS = 8'h0C;
  localparam logic [7:0] OFF_DIETEMP = 8'h10;
  localparam logic [7:0] OFF_POWER = 8'h14;
  localparam logic [7:0] OFF_ENERGY = 8'h18;
  localparam logic [7:0] OFF_CHARGE = 8'h1C;
  localparam logic [7:0] OFF_DIAG = 8'h20;

  // field positions
  localparam int DLY_LSB = 6;
  localparam int MODE_LSB = 12;
  localparam int VCT_LSB = 9;
  localparam int SCT_LSB = 6;
  localparam int TCT_LSB = 3;
  localparam int AVG_LSB = 0;
  localparam int DIAG_DONE_BIT = 1;
  localparam int DIAG_ACCV_BIT = 0;

  // reset values: continuous all inputs, 1052 us each, one average
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_ADC_CFG = 32'h0000_7B68;

  // times in microseconds
  localparam logic [18:0] STARTUP_US = 19'h0_012C;
  localparam logic [18:0] DLY_STEP_US = 19'h0_07D0;
  // 50 84 150 280 540 1052 2074 4120 us
  localparam logic [12:0] CT_US [8] = '{13'h0032, 13'h0054, 13'h0096, 13'h0118,
                                        13'h021C, 13'h041C, 13'h081A, 13'h1018};
  // log2 of 1 4 16 64 128 256 512 1024 averages
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
                                           4'h7, 4'h8, 4'h9, 4'hA};

  typedef enum logic [1:0] {STP_TEMP, STP_SHUNT, STP_BUS} pmcs_step_e;
  typedef enum logic [1:0] {ST_WARM, ST_IDLE, ST_DELAY, ST_CONV} pmcs_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pmcs_bus_s;

  typedef struct packed {
    pmcs_step_e sel;
    logic start;
    logic [2:0] ctCode;
  } pmcs_adc_s;

endpackage

`default_nettype wire

// ---- core/pmcs_sequencer.sv ----
/*
  conversion sequencer and calculation engine of the power monitor
  assumes the converter runs on the same clock and holds adcData valid
  when the programmed conversion period ends
*/
// Chosen here: the address-and-strobe port and the register offsets.
`default_nettype none

module pmcs_sequencer import pmcs_pkg::*; #(
  parameter int US_CYCLES = 1000 / CLK_PERIOD_NS,
  parameter int TC_SHIFT = 12,
  parameter logic signed [15:0] TEMP_REF = 16'sh0000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire pmcs_bus_s busIn,
  output logic [31:0] rdData,
  // converter
  input wire logic [15:0] adcData,
  output pmcs_adc_s adcCtl
);

  localparam int DIV_W = $clog2(US_CYCLES);

  typedef struct packed {
    pmcs_state_e state;
    pmcs_step_e step;
    logic [DIV_W-1:0] usDiv;
    logic [18:0] usCnt;
    logic [10:0] avgCnt;
    logic [31:0] cfg;
    logic [31:0] adcCfg;
    logic signed [25:0] accT;
    logic signed [25:0] accS;
    logic signed [25:0] accB;
    logic signed [15:0] tempSmp;
    logic signed [15:0] curSmp;
    logic [15:0] curr;
    logic [15:0] vbus;
    logic [15:0] temp;
    logic [31:0] power;
    logic [31:0] energy;
    logic [31:0] charge;
    logic convDone;
    logic accValid;
    logic loadEvt;
    logic pubEvt;
    logic [31:0] rdData;
    pmcs_adc_s adc;
  } pmcs_seq_s;

  pmcs_seq_s seq_ff;
  pmcs_seq_s nxt_seq;
  logic cfgWr;

  assign cfgWr = busIn.wr && (busIn.addr == OFF_ADC_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic tick;
    logic [2:0] mode;
    logic [2:0] newMode;
    logic startConv;
    pmcs_step_e startStep;
    logic beginSeq;
    logic setDone;
    logic clrDone;
    logic signed [15:0] smp;
    logic signed [16:0] dT;
    logic signed [32:0] prod;
    logic signed [15:0] corr;
    logic signed [31:0] pwr;
    logic signed [25:0] sumT;
    logic signed [25:0] sumS;
    logic signed [25:0] sumB;
    logic signed [25:0] avgS;
    logic signed [25:0] avgB;
    logic signed [25:0] avgT;
    logic [3:0] sh;
    logic avgOne;
    logic cycEnd;
    logic [10:0] avgNext;
    logic [2:0] code;
    tick = 1'b0;
    mode = 3'h0;
    newMode = 3'h0;
    startConv = 1'b0;
    startStep = STP_TEMP;
    beginSeq = 1'b0;
    setDone = 1'b0;
    clrDone = 1'b0;
    smp = 16'sh0000;
    dT = 17'sh0_0000;
    prod = 33'sh0_0000_0000;
    corr = 16'sh0000;
    pwr = 32'sh0000_0000;
    sumT = 26'sh000_0000;
    sumS = 26'sh000_0000;
    sumB = 26'sh000_0000;
    avgS = 26'sh000_0000;
    avgB = 26'sh000_0000;
    avgT = 26'sh000_0000;
    sh = 4'h0;
    avgOne = 1'b0;
    cycEnd = 1'b0;
    avgNext = 11'h000;
    code = 3'h0;

    nxt_seq = seq_ff;
    nxt_seq.adc.start = 1'b0;
    nxt_seq.loadEvt = 1'b0;
    nxt_seq.pubEvt = 1'b0;
    nxt_seq.rdData = 32'h0000_0000;

    // microsecond time base from the oscillator clock
    tick = (seq_ff.usDiv == DIV_W'(US_CYCLES - 1)); // R22
    nxt_seq.usDiv = tick ? '0 : seq_ff.usDiv + 1'b1;
    if (tick && (seq_ff.usCnt != 19'h0_0000)) begin
      nxt_seq.usCnt = seq_ff.usCnt - 19'h0_0001;
    end

    mode = seq_ff.adcCfg[MODE_LSB +: 3];
    sh = AVG_SHIFT[seq_ff.adcCfg[AVG_LSB +: 3]]; // R21
    avgOne = (sh == 4'h0);
    avgNext = seq_ff.avgCnt + 11'h001;
    // bit0 current, bit1 bus, bit2 continuous
    startStep = mode[0] ? STP_TEMP : STP_BUS; // R08 R07

    case (seq_ff.state)
      ST_WARM: begin
        // converter and clock settle before the first conversion
        if (seq_ff.usCnt == 19'h0_0000) begin // R22
          nxt_seq.state = ST_IDLE;
          beginSeq = (mode[1:0] != 2'h0);
        end
      end
      ST_IDLE: begin
        nxt_seq.state = ST_IDLE; // R23
      end
      ST_DELAY: begin
        if (seq_ff.usCnt == 19'h0_0000) begin // R19
          startConv = 1'b1;
        end
      end
      ST_CONV: begin
        if (seq_ff.usCnt == 19'h0_0000) begin
          smp = signed'(adcData);
          sumT = seq_ff.accT;
          sumS = seq_ff.accS;
          sumB = seq_ff.accB;
          case (seq_ff.step)
            STP_TEMP: begin
              nxt_seq.tempSmp = smp;
              sumT = seq_ff.accT + 26'(smp); // R04
              nxt_seq.accT = sumT;
              if (avgOne) begin
                nxt_seq.temp = adcData; // R03
                nxt_seq.pubEvt = 1'b1;
              end
              startConv = 1'b1;
              startStep = STP_SHUNT; // R07
            end
            STP_SHUNT: begin
              // drift correction from the temperature just converted
              dT = 17'(seq_ff.tempSmp) - 17'(TEMP_REF); // R07
              prod = 33'(smp) * 33'(dT);
              corr = smp - prod[TC_SHIFT +: 16]; // R10
              nxt_seq.curSmp = corr;
              sumS = seq_ff.accS + 26'(corr); // R04
              nxt_seq.accS = sumS;
              nxt_seq.charge = seq_ff.charge + 32'(corr); // R05 R06
              if (avgOne) begin
                nxt_seq.curr = corr; // R03
                nxt_seq.pubEvt = 1'b1;
              end
              if (mode[1]) begin
                startConv = 1'b1;
                startStep = STP_BUS; // R11
              end else begin
                cycEnd = 1'b1;
              end
            end
            default: begin
              // previous current with the newest bus sample
              pwr = 32'(seq_ff.curSmp) * 32'(smp); // R02 R06
              sumB = seq_ff.accB + 26'(smp); // R04
              nxt_seq.accB = sumB;
              nxt_seq.energy = seq_ff.energy + pwr; // R05
              if (avgOne) begin
                nxt_seq.vbus = adcData; // R03
                nxt_seq.power = pwr;
                nxt_seq.pubEvt = 1'b1;
              end
              cycEnd = 1'b1;
            end
          endcase
          if (cycEnd) begin
            nxt_seq.avgCnt = avgNext;
            if (avgNext == (11'h001 << sh)) begin // R11 R16
              if (!avgOne) begin
                avgS = sumS >>> sh; // R24
                avgB = sumB >>> sh;
                avgT = sumT >>> sh;
                // every output of the sequence in one cycle
                if (mode[0]) begin // R25 R04
                  nxt_seq.curr = avgS[15:0];
                  nxt_seq.temp = avgT[15:0];
                end
                if (mode[1]) begin
                  nxt_seq.vbus = avgB[15:0];
                  pwr = 32'(seq_ff.curSmp) * 32'(avgB[15:0]); // R02
                  if (mode[0]) begin
                    pwr = 32'(avgS[15:0]) * 32'(avgB[15:0]);
                  end
                  nxt_seq.power = pwr;
                end
                nxt_seq.pubEvt = 1'b1;
              end
              setDone = 1'b1; // R16
              nxt_seq.loadEvt = 1'b1;
              nxt_seq.accValid = mode[2]; // R18
              nxt_seq.accT = 26'sh000_0000;
              nxt_seq.accS = 26'sh000_0000;
              nxt_seq.accB = 26'sh000_0000;
              nxt_seq.avgCnt = 11'h000;
              if (mode[2]) begin
                startConv = 1'b1; // R13
                startStep = mode[0] ? STP_TEMP : STP_BUS;
              end else begin
                nxt_seq.state = ST_IDLE; // R14
              end
            end else begin
              startConv = 1'b1; // R11
              startStep = mode[0] ? STP_TEMP : STP_BUS;
            end
          end
        end
      end
      default: begin
        nxt_seq.state = ST_IDLE;
      end
    endcase

    // register writes
    if (busIn.wr) begin
      case (busIn.addr)
        OFF_CONFIG: begin
          nxt_seq.cfg = {16'h0000, busIn.wdata[15:0]} & 32'h0000_3FC0; // R19
        end
        OFF_ADC_CFG: begin
          nxt_seq.adcCfg = {16'h0000, busIn.wdata[15:0]};
          newMode = busIn.wdata[MODE_LSB +: 3];
          clrDone = (newMode[1:0] != 2'h0); // R17
          if (seq_ff.state != ST_WARM) begin
            // abort whatever runs and start over unless the new mode is shutdown
            startConv = 1'b0; // R15
            nxt_seq.accT = 26'sh000_0000;
            nxt_seq.accS = 26'sh000_0000;
            nxt_seq.accB = 26'sh000_0000;
            nxt_seq.avgCnt = 11'h000;
            nxt_seq.state = ST_IDLE; // R23
            beginSeq = (newMode[1:0] != 2'h0); // R14 R15
            mode = newMode;
            startStep = newMode[0] ? STP_TEMP : STP_BUS;
          end
        end
        default: begin
        end
      endcase
    end

    // reads never touch the sequence
    if (busIn.rd) begin // R12
      case (busIn.addr)
        OFF_CONFIG: nxt_seq.rdData = seq_ff.cfg;
        OFF_ADC_CFG: nxt_seq.rdData = seq_ff.adcCfg;
        OFF_CURRENT: nxt_seq.rdData = {16'h0000, seq_ff.curr};
        OFF_VBUS: nxt_seq.rdData = {16'h0000, seq_ff.vbus};
        OFF_DIETEMP: nxt_seq.rdData = {16'h0000, seq_ff.temp};
        OFF_POWER: nxt_seq.rdData = seq_ff.power;
        OFF_ENERGY: nxt_seq.rdData = seq_ff.energy;
        OFF_CHARGE: nxt_seq.rdData = seq_ff.charge;
        OFF_DIAG: begin
          nxt_seq.rdData[DIAG_DONE_BIT] = seq_ff.convDone;
          nxt_seq.rdData[DIAG_ACCV_BIT] = seq_ff.accValid;
          clrDone = 1'b1; // R17
        end
        default: nxt_seq.rdData = 32'h0000_0000;
      endcase
    end

    // start delay only at the head of a fresh sequence
    if (beginSeq) begin
      if (seq_ff.cfg[DLY_LSB +: 8] == 8'h00) begin
        startConv = 1'b1;
      end else begin
        nxt_seq.state = ST_DELAY; // R19
        nxt_seq.usCnt = 19'(seq_ff.cfg[DLY_LSB +: 8]) * DLY_STEP_US;
      end
    end

    if (startConv) begin
      case (startStep)
        STP_TEMP: code = seq_ff.adcCfg[TCT_LSB +: 3]; // R09
        STP_SHUNT: code = seq_ff.adcCfg[SCT_LSB +: 3];
        default: code = seq_ff.adcCfg[VCT_LSB +: 3];
      endcase
      if (busIn.wr && (busIn.addr == OFF_ADC_CFG)) begin
        case (startStep)
          STP_TEMP: code = busIn.wdata[TCT_LSB +: 3];
          STP_SHUNT: code = busIn.wdata[SCT_LSB +: 3];
          default: code = busIn.wdata[VCT_LSB +: 3];
        endcase
      end
      nxt_seq.state = ST_CONV;
      nxt_seq.step = startStep;
      nxt_seq.usCnt = 19'(CT_US[code]); // R09
      nxt_seq.adc.sel = startStep; // R01
      nxt_seq.adc.start = 1'b1;
      nxt_seq.adc.ctCode = code; // R20
    end

    // a completing sequence beats a clear in the same cycle
    nxt_seq.convDone = (seq_ff.convDone & ~clrDone) | setDone;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= '0;
      seq_ff.usCnt <= STARTUP_US;
      seq_ff.cfg <= RST_CONFIG;
      seq_ff.adcCfg <= RST_ADC_CFG;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  assign rdData = seq_ff.rdData;
  assign adcCtl = seq_ff.adc;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_modeWr;
    cfgWr && (busIn.wdata[MODE_LSB +: 2] != 2'h0) && (seq_ff.state != ST_WARM);
  endsequence

  sequence s_restarted;
    ((seq_ff.state == ST_DELAY) || (seq_ff.adc.start && (seq_ff.state == ST_CONV)))
      && (seq_ff.avgCnt == 11'h000) && (seq_ff.accS == 26'sh000_0000);
  endsequence

  done_set_a: assert property ($rose(seq_ff.convDone) |-> seq_ff.loadEvt) // R16
    else $error("done flag rose without a finished sequence");

  done_wrclr_a: assert property (s_modeWr |=> (!seq_ff.convDone || seq_ff.loadEvt)) // R17
    else $error("done flag survived a setup write");

  done_rdclr_a: assert property ((busIn.rd && (busIn.addr == OFF_DIAG)) // R17
      |=> (!seq_ff.convDone || seq_ff.loadEvt))
    else $error("done flag survived an alert register read");

  temp_first_a: assert property ((seq_ff.adc.start && (seq_ff.adc.sel == STP_SHUNT)) // R07
      |-> ($past(seq_ff.step) == STP_TEMP) && ($past(seq_ff.usCnt) == 19'h0_0000))
    else $error("shunt conversion not preceded by temperature");

  result_hold_a: assert property (($changed(seq_ff.curr) || $changed(seq_ff.vbus) // R12
      || $changed(seq_ff.temp) || $changed(seq_ff.power)) |-> seq_ff.pubEvt)
    else $error("result register changed without a completed result");

  mode_restart_a: assert property (s_modeWr |=> s_restarted) // R15
    else $error("mode write did not restart the sequence");

  one_shot_a: assert property ((seq_ff.loadEvt && !seq_ff.adcCfg[MODE_LSB + 2] // R14
      && !$past(cfgWr)) |-> (seq_ff.state == ST_IDLE))
    else $error("triggered sequence did not shut down");

  cont_loop_a: assert property ((seq_ff.loadEvt && seq_ff.adcCfg[MODE_LSB + 2] // R13
      && !$past(cfgWr)) |-> (seq_ff.state == ST_CONV) && seq_ff.adc.start)
    else $error("continuous sequence did not restart");

  acc_valid_a: assert property ((seq_ff.loadEvt && !$past(cfgWr)) // R18
      |-> (seq_ff.accValid == seq_ff.adcCfg[MODE_LSB + 2]))
    else $error("accumulation validity does not follow the mode");

  idle_stay_a: assert property (((seq_ff.state == ST_IDLE) && !cfgWr) // R23
      |=> (seq_ff.state == ST_IDLE))
    else $error("left shutdown without a mode write");

  delay_hold_a: assert property (((seq_ff.state == ST_DELAY) // R19
      && (seq_ff.usCnt > 19'h0_0001) && !cfgWr) |=> (seq_ff.state == ST_DELAY))
    else $error("conversion started before the delay ran out");

  avg1_pub_a: assert property (((seq_ff.state == ST_CONV) && (seq_ff.step == STP_BUS) // R03
      && (seq_ff.usCnt == 19'h0_0000) && (seq_ff.adcCfg[AVG_LSB +: 3] == 3'h0) && !cfgWr)
      |=> (seq_ff.vbus == $past(adcData)))
    else $error("single-average bus result not published at conversion end");

endmodule // pmcs_sequencer

`default_nettype wire

// ---- sim/pmcs_adc_model.sv ----
/*
  behavioural model of the shared converter behind the sequencer
  assumes the sequencer pulses adcCtl.start and holds sel and ctCode per conversion
*/
`default_nettype none

module pmcs_adc_model import pmcs_pkg::*; #(
  parameter int US_CYCLES = 2,
  parameter logic [15:0] TEMP_VAL = 16'h0010,
  parameter logic [15:0] SHUNT_VAL = 16'h1000,
  parameter logic [15:0] BUS_VAL = 16'h0100
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // converter side
  input wire pmcs_adc_s adcCtl,
  output var logic [15:0] adcData
);
  pmcs_step_e curSel;
  int count;
  int limit;
  logic [15:0] val;

  always_comb begin
    case (curSel)
      STP_TEMP: val = TEMP_VAL;
      STP_SHUNT: val = SHUNT_VAL;
      default: val = BUS_VAL;
    endcase
  end

  // result stands two ticks past the period, then turns over so stale reads show
  always_comb adcData = (count < limit) ? val : ~val;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      curSel <= STP_TEMP;
      count <= 0;
      limit <= 0;
    end else if (adcCtl.start) begin
      curSel <= adcCtl.sel;
      count <= 0;
      limit <= (int'(CT_US[adcCtl.ctCode]) + 2) * US_CYCLES;
    end else if (count < limit) begin
      count <= count + 1;
    end
  end
endmodule // pmcs_adc_model

`default_nettype wire

// ---- sim/pmcs_sequencer_tb_top.sv ----
/*
  self-checking bench of the conversion sequencer
  assumes the converter model answers every conversion with fixed per-input values
*/
`default_nettype none

module pmcs_sequencer_tb_top;
  import pmcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int USC = 2;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  pmcs_bus_s busIn = '0;
  logic [31:0] rdData;
  logic [15:0] adcData;
  pmcs_adc_s adcCtl;
  int mismatches = 0;
  int cmp_count = 0;
  int nSel [3];
  logic [31:0] d;
  int n;

  always #4 clock = ~clock;

  pmcs_sequencer #(.US_CYCLES(USC)) DUT (
    .clock(clock), .rst_n(rst_n), .busIn(busIn), .rdData(rdData),
    .adcData(adcData), .adcCtl(adcCtl));

  pmcs_adc_model #(.US_CYCLES(USC)) adcModel (
    .clock(clock), .rst_n(rst_n), .adcCtl(adcCtl), .adcData(adcData));

  // count conversions started per input
  always @(posedge clock) begin
    if (adcCtl.start === 1'b1) begin
      nSel[adcCtl.sel] = nSel[adcCtl.sel] + 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkIn(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    busIn <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busIn.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    busIn <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busIn.rd <= 1'b0;
    #1;
    v = rdData;
  endtask

  task automatic clrCounts();
    nSel = '{0, 0, 0};
  endtask

  task automatic waitDone(output logic [31:0] v);
    int i;
    v = '0;
    for (i = 0; i < 4000 && v[DIAG_DONE_BIT] !== 1'b1; i++) begin
      rd(OFF_DIAG, v);
    end
    chk(32'(v[DIAG_DONE_BIT]), 32'h0000_0001);
  endtask

  task automatic chkCounts(input int t, input int s, input int b);
    chk(32'(nSel[0]), 32'(t));
    chk(32'(nSel[1]), 32'(s));
    chk(32'(nSel[2]), 32'(b));
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #(30000 * 8);
    mismatches++;
    report_and_stop();
  end

  initial begin
    clrCounts();
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFF_CONFIG, d);
    chk(d, RST_CONFIG);
    rd(8'h24, d);
    chk(d, 32'h0000_0000);
    rd(OFF_ADC_CFG, d);
    chk(d, RST_ADC_CFG);
    @(posedge clock);
    #1;
    chk(rdData, 32'h0000_0000);
    // triggered, four averages, shortest periods
    wr(OFF_ADC_CFG, 32'h0000_3001);
    clrCounts();
    // nothing converts while the time base settles
    repeat (500) @(posedge clock);
    chkCounts(0, 0, 0);
    waitDone(d);
    chk(32'(d[DIAG_ACCV_BIT]), 32'h0000_0000);
    chkCounts(4, 4, 4);
    rd(OFF_CURRENT, d);
    chk(d, 32'h0000_0FF0);
    rd(OFF_VBUS, d);
    chk(d, 32'h0000_0100);
    rd(OFF_DIETEMP, d);
    chk(d, 32'h0000_0010);
    rd(OFF_POWER, d);
    chk(d, 32'h000F_F000);
    rd(OFF_DIAG, d);
    chk(32'(d[DIAG_DONE_BIT]), 32'h0000_0000);
    repeat (300) @(posedge clock);
    chkCounts(4, 4, 4);
    // current only and bus only, one average
    rd(OFF_CHARGE, d);
    n = int'(d);
    wr(OFF_ADC_CFG, 32'h0000_1000);
    clrCounts();
    waitDone(d);
    chkCounts(1, 1, 0);
    rd(OFF_CURRENT, d);
    chk(d, 32'h0000_0FF0);
    rd(OFF_CHARGE, d);
    chk(d - 32'(n), 32'h0000_0FF0);
    rd(OFF_ENERGY, d);
    n = int'(d);
    wr(OFF_ADC_CFG, 32'h0000_2000);
    clrCounts();
    waitDone(d);
    chkCounts(0, 0, 1);
    // bus sample times the current kept from the run before
    rd(OFF_ENERGY, d);
    chk(d - 32'(n), 32'h000F_F000);
    // shutdown write keeps the flag, a mode write clears it
    wr(OFF_ADC_CFG, 32'h0000_1000);
    repeat (400) @(posedge clock);
    wr(OFF_ADC_CFG, 32'h0000_0000);
    clrCounts();
    repeat (300) @(posedge clock);
    chkCounts(0, 0, 0);
    rd(OFF_DIAG, d);
    chk(32'(d[DIAG_DONE_BIT]), 32'h0000_0001);
    wr(OFF_ADC_CFG, 32'h0000_1000);
    repeat (400) @(posedge clock);
    wr(OFF_ADC_CFG, 32'h0000_1000);
    rd(OFF_DIAG, d);
    chk(32'(d[DIAG_DONE_BIT]), 32'h0000_0000);
    // continuous keeps looping and keeps the accumulators valid
    wr(OFF_ADC_CFG, 32'h0000_7000);
    waitDone(d);
    waitDone(d);
    chk(32'(d[DIAG_ACCV_BIT]), 32'h0000_0001);
    repeat (20) @(posedge clock);
    wr(OFF_ADC_CFG, 32'h0000_7028);
    chk(32'(adcCtl.start), 32'h0000_0001);
    chk(32'(adcCtl.ctCode), 32'h0000_0005);
    chk(32'(adcCtl.sel), 32'(STP_TEMP));
    // start delay of one step
    wr(OFF_ADC_CFG, 32'h0000_0000);
    wr(OFF_CONFIG, 32'h0000_0040);
    rd(OFF_CONFIG, d);
    chk(d, 32'h0000_0040);
    wr(OFF_ADC_CFG, 32'h0000_3000);
    n = 0;
    while (adcCtl.start !== 1'b1 && n < 6000) begin
      @(posedge clock);
      #1;
      n++;
    end
    chkIn(n, 2000 * USC - 10, 2000 * USC + 10);
    report_and_stop();
  end
endmodule // pmcs_sequencer_tb_top

`default_nettype wire
